// file: rtl/ptb_bar_bank.sv
// Target window base registers and subsystem identity of the bus controller.
// Access port is same-clock; addresses 0x00xx (header view) or 0xd0xx
// (controller view) reach the same registers. Target address to decode
// and the space enables come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module ptb_bar_bank
    import ptb_pkg::*;
#(
    // Arbitrary neutral identity values until a load replaces them
    parameter logic [15:0] SUBSYS_ID_DEFAULT     = 16'h5a01,
    parameter logic [15:0] SUBSYS_VENDOR_DEFAULT = 16'h5a02
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        acc_req,
    input  wire logic        acc_we,
    input  wire logic [15:0] acc_addr,
    input  wire logic [3:0]  acc_be,
    input  wire logic [31:0] acc_wdata,
    output logic      [31:0] acc_rdata_r,
    output logic             acc_ack_r,
    input  wire logic        id_load,
    input  wire logic [15:0] id_load_subsystem_identifier,
    input  wire logic [15:0] id_load_subsystem_vendor_identifier,
    input  wire logic        mem_decode_enable,
    input  wire logic        io_decode_enable,
    input  wire logic        tgt_valid,
    input  wire logic [31:0] tgt_addr,
    input  wire logic        tgt_is_io,
    input  wire logic        tgt_dual_addr,
    output logic      [3:0]  tgt_hit_r,
    output logic             tgt_valid_r
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic        page_ok;
    logic [15:0] reg_off;
    logic        wr_go;
    logic [PTB_NWIN-1:0] win_sel;
    logic        sel_subsys;

    // Both views share the low byte; upper page selects the view
    assign page_ok = ((acc_addr & PTB_PAGE_MASK) == PTB_CTRL_PAGE)
                  || ((acc_addr & PTB_PAGE_MASK) == PTB_HDR_PAGE);
    assign reg_off = PTB_CTRL_PAGE | (acc_addr & ~PTB_PAGE_MASK);
    assign wr_go   = acc_req && acc_we && page_ok;

    always_comb begin
        win_sel    = '0;
        sel_subsys = 1'b0;
        if (page_ok) begin
            unique case (reg_off)
                PTB_OFF_MEM0:   win_sel[PTB_WIN_MEM0] = 1'b1;
                PTB_OFF_MEM1:   win_sel[PTB_WIN_MEM1] = 1'b1;
                PTB_OFF_MEM2:   win_sel[PTB_WIN_MEM2] = 1'b1;
                PTB_OFF_IO:     win_sel[PTB_WIN_IO]   = 1'b1;
                PTB_OFF_SUBSYS: sel_subsys = 1'b1;
                default:        sel_subsys = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Window registers
    // ----------------------------------------
    logic [31:0] win_val [PTB_NWIN];

    ptb_win_reg #(.WMASK(PTB_MEM0_BASE_MASK), .FIXED(PTB_MEM0_FIXED)) u_mem0 (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr_en    (wr_go && win_sel[PTB_WIN_MEM0]),
        .wr_be    (acc_be),
        .wr_data  (acc_wdata),
        .value    (win_val[PTB_WIN_MEM0])
    );

    ptb_win_reg #(.WMASK(PTB_MEM1_BASE_MASK), .FIXED(PTB_MEM1_FIXED)) u_mem1 (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr_en    (wr_go && win_sel[PTB_WIN_MEM1]),
        .wr_be    (acc_be),
        .wr_data  (acc_wdata),
        .value    (win_val[PTB_WIN_MEM1])
    );

    ptb_win_reg #(.WMASK(PTB_MEM2_BASE_MASK), .FIXED(PTB_MEM2_FIXED)) u_mem2 (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr_en    (wr_go && win_sel[PTB_WIN_MEM2]),
        .wr_be    (acc_be),
        .wr_data  (acc_wdata),
        .value    (win_val[PTB_WIN_MEM2])
    );

    ptb_win_reg #(.WMASK(PTB_IO_BASE_MASK), .FIXED(PTB_IO_FIXED)) u_io (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr_en    (wr_go && win_sel[PTB_WIN_IO]),
        .wr_be    (acc_be),
        .wr_data  (acc_wdata),
        .value    (win_val[PTB_WIN_IO])
    );

    // ----------------------------------------
    // Subsystem identity
    // ----------------------------------------
    logic [15:0] subsys_id_r;
    logic [15:0] subsys_vendor_r;

    // Bus writes never reach it; only the init load does
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            subsys_id_r     <= SUBSYS_ID_DEFAULT;
            subsys_vendor_r <= SUBSYS_VENDOR_DEFAULT;
        end else if (id_load) begin
            subsys_id_r     <= id_load_subsystem_identifier;
            subsys_vendor_r <= id_load_subsystem_vendor_identifier;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] rd_mux;

    // Upper base registers and unmapped offsets read zero, writes dropped
    always_comb begin
        rd_mux = PTB_RDATA_ZERO;
        for (int i = 0; i < PTB_NWIN; i++) begin
            if (win_sel[i]) begin
                rd_mux = win_val[i];
            end
        end
        if (sel_subsys) begin
            rd_mux = {subsys_id_r, subsys_vendor_r};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ack_r   <= 1'b0;
            acc_rdata_r <= PTB_RDATA_ZERO;
        end else begin
            acc_ack_r <= acc_req;
            if (acc_req && !acc_we) begin
                acc_rdata_r <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Target window hit decode
    // ----------------------------------------
    logic [31:0] win_mask [PTB_NWIN];
    logic [3:0]  hit_nxt;

    assign win_mask[PTB_WIN_MEM0] = PTB_MEM0_BASE_MASK;
    assign win_mask[PTB_WIN_MEM1] = PTB_MEM1_BASE_MASK;
    assign win_mask[PTB_WIN_MEM2] = PTB_MEM2_BASE_MASK;
    assign win_mask[PTB_WIN_IO]   = PTB_IO_BASE_MASK;

    // Overlapping memory windows may all hit; the consumer arbitrates
    always_comb begin
        hit_nxt = '0;
        if (tgt_valid && !tgt_dual_addr) begin
            for (int i = 0; i < PTB_NWIN; i++) begin
                if ((tgt_addr & win_mask[i]) == (win_val[i] & win_mask[i])) begin
                    if (i == PTB_WIN_IO) begin
                        hit_nxt[i] = tgt_is_io && io_decode_enable;
                    end else begin
                        hit_nxt[i] = !tgt_is_io && mem_decode_enable;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_hit_r   <= '0;
            tgt_valid_r <= 1'b0;
        end else begin
            tgt_hit_r   <= hit_nxt;
            tgt_valid_r <= tgt_valid;
        end
    end

endmodule
`default_nettype wire

// file: rtl/ptb_pkg.sv
// Package for the target window register bank.
// Shared by the bank top and its window register cell; no outside assumptions.
package ptb_pkg;

    // ----------------------------------------
    // Register offsets, controller space
    // ----------------------------------------
    localparam logic [15:0] PTB_OFF_MEM0      = 16'hd010;
    localparam logic [15:0] PTB_OFF_MEM0_UP   = 16'hd014;
    localparam logic [15:0] PTB_OFF_MEM1      = 16'hd018;
    localparam logic [15:0] PTB_OFF_MEM1_UP   = 16'hd01c;
    localparam logic [15:0] PTB_OFF_MEM2      = 16'hd020;
    localparam logic [15:0] PTB_OFF_IO        = 16'hd024;
    localparam logic [15:0] PTB_OFF_SUBSYS    = 16'hd02c;

    // ----------------------------------------
    // Header view of the same registers
    // ----------------------------------------
    localparam logic [15:0] PTB_CTRL_PAGE     = 16'hd000;
    localparam logic [15:0] PTB_HDR_PAGE      = 16'h0000;
    localparam logic [15:0] PTB_PAGE_MASK     = 16'hff00;

    // ----------------------------------------
    // Window base fields
    // ----------------------------------------
    localparam logic [31:0] PTB_MEM0_BASE_MASK = 32'he000_0000;
    localparam logic [31:0] PTB_MEM1_BASE_MASK = 32'hff00_0000;
    localparam logic [31:0] PTB_MEM2_BASE_MASK = 32'hfff0_0000;
    localparam logic [31:0] PTB_IO_BASE_MASK   = 32'hffff_ff00;
    localparam logic [31:0] PTB_BASE_RESET     = 32'h0000_0000;

    // ----------------------------------------
    // Fixed low bits
    // ----------------------------------------
    localparam int          PTB_PREFETCH_BIT   = 3;
    localparam int          PTB_SPACE_BIT      = 0;
    localparam logic [31:0] PTB_PREFETCH_FLAG  = 32'h0000_0008;
    localparam logic [31:0] PTB_MEM_TYPE_32    = 32'h0000_0000;
    localparam logic [31:0] PTB_MEM_SPACE_IND  = 32'h0000_0000;
    localparam logic [31:0] PTB_IO_SPACE_IND   = 32'h0000_0001;
    localparam logic [31:0] PTB_MEM0_FIXED = PTB_PREFETCH_FLAG | PTB_MEM_TYPE_32 | PTB_MEM_SPACE_IND;
    localparam logic [31:0] PTB_MEM1_FIXED = PTB_PREFETCH_FLAG | PTB_MEM_TYPE_32 | PTB_MEM_SPACE_IND;
    localparam logic [31:0] PTB_MEM2_FIXED = PTB_MEM_TYPE_32 | PTB_MEM_SPACE_IND;
    localparam logic [31:0] PTB_IO_FIXED   = PTB_IO_SPACE_IND;

    // ----------------------------------------
    // Subsystem identity fields
    // ----------------------------------------
    localparam int          PTB_SUBSYSTEM_IDENTIFIER_LSB       = 16;
    localparam int          PTB_SUBSYSTEM_VENDOR_IDENTIFIER_LSB      = 0;
    localparam logic [31:0] PTB_RDATA_ZERO     = 32'h0000_0000;

    // ----------------------------------------
    // Window indices
    // ----------------------------------------
    localparam int          PTB_WIN_MEM0       = 0;
    localparam int          PTB_WIN_MEM1       = 1;
    localparam int          PTB_WIN_MEM2       = 2;
    localparam int          PTB_WIN_IO         = 3;
    localparam int          PTB_NWIN           = 4;

endpackage

// file: rtl/ptb_win_reg.sv
// One window base register: writable base field, constant low bits.
// Assumes a same-clock write strobe with byte enables from the bank top.
`timescale 1ns/1ps
`default_nettype none
module ptb_win_reg
    import ptb_pkg::*;
#(
    parameter logic [31:0] WMASK = 32'hffff_ffff,
    parameter logic [31:0] FIXED = 32'h0000_0000
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_be,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] value
);

    logic [31:0] base_r;
    logic [31:0] lane_mask;

    assign lane_mask = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}};

    // Only masked bits are stored, so all-ones sizing reads back the window size
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_r <= PTB_BASE_RESET;
        end else if (wr_en) begin
            base_r <= (base_r & ~(WMASK & lane_mask)) | (wr_data & WMASK & lane_mask);
        end
    end

    assign value = (base_r & WMASK) | FIXED;

endmodule
`default_nettype wire

// file: verification/ptb_bar_bank_properties.sv
// Checker for the window bank: access answers, fixed low bits, decode.
// Bound to every ptb_bar_bank; sees its top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module ptb_bar_bank_properties (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        acc_req,
    input wire logic        acc_we,
    input wire logic [15:0] acc_addr,
    input wire logic [31:0] acc_rdata_r,
    input wire logic        acc_ack_r,
    input wire logic        mem_decode_enable,
    input wire logic        io_decode_enable,
    input wire logic        tgt_valid,
    input wire logic        tgt_is_io,
    input wire logic        tgt_dual_addr,
    input wire logic [3:0]  tgt_hit_r
);
    logic        rd_q;
    logic [15:0] off_q;
    // Last read, so its answer can be judged
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_q  <= 1'b0;
            off_q <= 16'h0000;
        end else begin
            rd_q  <= acc_req && !acc_we;
            off_q <= acc_addr;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_ack; acc_req |=> acc_ack_r; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ack_cause; acc_ack_r |-> $past(acc_req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_mem0; acc_ack_r && rd_q && off_q == 16'hd010 |-> acc_rdata_r[28:0] == 29'h8;
    endproperty
    a_mem0: assert property (p_mem0) else $error("window 0 low bits");
    property p_mem1; acc_ack_r && rd_q && off_q == 16'hd018 |-> acc_rdata_r[23:0] == 24'h8;
    endproperty
    a_mem1: assert property (p_mem1) else $error("window 1 low bits");
    property p_mem2; acc_ack_r && rd_q && off_q == 16'hd020 |-> acc_rdata_r[19:0] == 20'h0;
    endproperty
    a_mem2: assert property (p_mem2) else $error("window 2 low bits");
    property p_io; acc_ack_r && rd_q && off_q == 16'hd024 |-> acc_rdata_r[7:0] == 8'h01;
    endproperty
    a_io: assert property (p_io) else $error("io window low bits");
    property p_dual; tgt_valid && tgt_dual_addr |=> tgt_hit_r == 4'h0; endproperty
    a_dual: assert property (p_dual) else $error("dual cycle hit");
    property p_mem_en; |tgt_hit_r[2:0] |-> $past(mem_decode_enable) && !$past(tgt_is_io);
    endproperty
    a_mem_en: assert property (p_mem_en) else $error("memory hit while off");
    property p_io_en; tgt_hit_r[3] |-> $past(io_decode_enable) && $past(tgt_is_io); endproperty
    a_io_en: assert property (p_io_en) else $error("io hit while off");
endmodule
bind ptb_bar_bank ptb_bar_bank_properties ptb_bar_bank_properties_i (.core_clk, .rst_b,
    .acc_req, .acc_we, .acc_addr, .acc_rdata_r, .acc_ack_r, .mem_decode_enable,
    .io_decode_enable, .tgt_valid, .tgt_is_io, .tgt_dual_addr, .tgt_hit_r);
`default_nettype wire

// file: verification/ptb_host_model.sv
// Host model issuing single-word configuration accesses.
// Assumes the bank acks one cycle after each one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module ptb_host_model (
    input  wire logic        core_clk,
    output logic             acc_req,
    output logic             acc_we,
    output logic      [15:0] acc_addr,
    output logic      [3:0]  acc_be,
    output logic      [31:0] acc_wdata,
    input  wire logic [31:0] acc_rdata_r,
    input  wire logic        acc_ack_r
);
    initial begin
        acc_req   = 1'b0;
        acc_we    = 1'b0;
        acc_addr  = 16'h0000;
        acc_be    = 4'h0;
        acc_wdata = 32'h0000_0000;
    end
    task automatic cfg(input logic we, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d, input int gap, output logic [31:0] q, output logic k);
        q = 32'h0;
        k = 1'b0;
        // Upper bases are unused; a host never writes them
        if (!(we && (a[7:0] == 8'h14 || a[7:0] == 8'h1c))) begin
            repeat (gap) @(negedge core_clk);
            @(negedge core_clk);
            acc_req   = 1'b1;
            acc_we    = we;
            acc_addr  = a;
            acc_be    = be;
            acc_wdata = d;
            @(negedge core_clk);
            acc_req   = 1'b0;
            // Released lines show junk, not the old value
            acc_addr  = ~a;
            acc_wdata = ~d;
            k = acc_ack_r;
            q = acc_rdata_r;
        end
    endtask
endmodule
`default_nettype wire

// file: verification/ptb_bar_bank_bench.sv
// Self-checking bench for the window bank, host model on the access port.
// Needs the bank, its checker and the host model compiled first.
`timescale 1ns/1ps
`default_nettype none
module ptb_bar_bank_bench;
    logic core_clk = 1'b0, rst_b = 1'b0, acc_req, acc_we, acc_ack_r, id_load = 1'b0;
    logic mem_en = 1'b0, io_en = 1'b0, tgt_valid = 1'b0, tgt_is_io = 1'b0, tgt_dual = 1'b0;
    logic tgt_valid_r;
    logic [3:0] acc_be, tgt_hit_r;
    logic [15:0] acc_addr, id_ss = 16'h0, id_sv = 16'h0;
    logic [31:0] acc_wdata, acc_rdata_r, tgt_addr = 32'h0;
    int n_fail = 0, checked = 0;
    always #20 core_clk = ~core_clk;
    ptb_bar_bank ptb_bar_bank_i (.core_clk, .rst_b, .acc_req, .acc_we, .acc_addr, .acc_be,
        .acc_wdata, .acc_rdata_r, .acc_ack_r, .id_load, .id_load_subsystem_identifier(id_ss),
        .id_load_subsystem_vendor_identifier(id_sv), .mem_decode_enable(mem_en),
        .io_decode_enable(io_en), .tgt_valid, .tgt_addr, .tgt_is_io,
        .tgt_dual_addr(tgt_dual), .tgt_hit_r, .tgt_valid_r);
    ptb_host_model ptb_host_model_i (.core_clk, .acc_req, .acc_we, .acc_addr, .acc_be,
        .acc_wdata, .acc_rdata_r, .acc_ack_r);
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic we, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [31:0] e);
        logic [31:0] q;
        logic k;
        ptb_host_model_i.cfg(we, a, be, d, we ? 2 : 0, q, k);
        chk("ack", {31'h0, k}, 32'h1);
        if (!we) chk($sformatf("read %h", a), q, e);
    endtask
    task automatic probe(input logic [31:0] a, input logic io, input logic dual,
        input logic [3:0] e);
        @(negedge core_clk);
        tgt_valid = 1'b1;
        tgt_addr  = a;
        tgt_is_io = io;
        tgt_dual  = dual;
        @(negedge core_clk);
        tgt_valid = 1'b0;
        tgt_addr  = ~a;
        chk($sformatf("hit %h", a), {28'h0, tgt_hit_r}, {28'h0, e});
        chk("valid", {31'h0, tgt_valid_r}, 32'h1);
    endtask
    task automatic end_of_test;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        acc(0, 16'hd010, 4'h0, 0, 32'h0000_0008);
        acc(0, 16'hd018, 4'h0, 0, 32'h0000_0008);
        acc(0, 16'hd020, 4'h0, 0, 32'h0000_0000);
        acc(0, 16'hd024, 4'h0, 0, 32'h0000_0001);
        acc(0, 16'hd02c, 4'h0, 0, 32'h5a01_5a02);
        $display("test reset done");
        acc(1, 16'hd010, 4'hf, '1, 0);
        acc(1, 16'h0018, 4'hf, '1, 0);
        acc(1, 16'hd020, 4'hf, '1, 0);
        acc(1, 16'h0024, 4'hf, '1, 0);
        acc(0, 16'hd010, 4'h0, 0, 32'he000_0008);
        acc(0, 16'h0018, 4'h0, 0, 32'hff00_0008);
        acc(0, 16'hd020, 4'h0, 0, 32'hfff0_0000);
        acc(0, 16'h0024, 4'h0, 0, 32'hffff_ff01);
        acc(1, 16'hd024, 4'h2, 0, 0);
        acc(0, 16'hd024, 4'h0, 0, 32'hffff_0001);
        $display("test sizing done");
        acc(1, 16'hd02c, 4'hf, 0, 0);
        acc(0, 16'hd02c, 4'h0, 0, 32'h5a01_5a02);
        acc(0, 16'hd014, 4'h0, 0, 32'h0);
        @(negedge core_clk);
        id_load = 1'b1;
        id_ss   = 16'h1234;
        id_sv   = 16'h4321;
        @(negedge core_clk);
        id_load = 1'b0;
        acc(0, 16'hd02c, 4'h0, 0, 32'h1234_4321);
        $display("test identity done");
        mem_en = 1'b1;
        io_en  = 1'b1;
        probe(32'hfff0_0040, 0, 0, 4'h7);
        probe(32'he000_0000, 0, 0, 4'h1);
        probe(32'hdfff_ffff, 0, 0, 4'h0);
        probe(32'hfff0_0040, 0, 1, 4'h0);
        probe(32'hffff_0010, 1, 0, 4'h8);
        mem_en = 1'b0;
        io_en  = 1'b0;
        probe(32'hfff0_0040, 0, 0, 4'h0);
        probe(32'hffff_0010, 1, 0, 4'h0);
        $display("test decode done");
        end_of_test();
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
